// ---- rtl/adc_sel_cfg.svh ----
// Purpose: constants for the converter input selection and sequencing block
// Assumes: 32-bit APB, word-aligned registers, 10 MHz pclk
// Notes: Contract list below
//
// Contract
// - Selection writes go to a CPU-visible buffer
// - Idle: buffer copied to converter every cycle
// - Conversion start freezes applied selection
// - Copying resumes in last conversion cycle
// - Start bit begins conversion next ADC edge
// - Safely written selection affects next conversion
// - Free running: next result uses old channel
// - Reference: supply, internal 1.1V, external pin
// - Halt in noise/idle sleep starts conversion
// - Early wake still raises completion request
// - Converter stays powered unless enable cleared
// - Conversion 13 cycles, first 25 cycles
// - Start bit reads one until completion
`ifndef ADC_SEL_CFG_SVH
`define ADC_SEL_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define ADDR_SELECT 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_PRESCALE 12'h00c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SEL_CHAN_LSB 0
`define SEL_CHAN_W 5
`define SEL_REF_LSB 6
`define CTL_ENABLE 7
`define CTL_START 6
`define CTL_AUTO 5
`define CTL_DONE 4
`define CTL_IRQ_EN 3
`define CTL_FREE 2
`define STA_BUSY 0
`define STA_FIRST 1
`define STA_REF_LSB 2
`define STA_CHAN_LSB 4
`define STA_IRQ 9

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SELECT_RESET 8'h00
`define PRESCALE_RESET 8'h01
`define NORMAL_CYCLES 5'd13
`define FIRST_CYCLES 5'd25

`endif

// ---- rtl/adc_sel_pkg.sv ----
// Purpose: types for the converter input selection block
// Assumes: nothing beyond the constants header
// Notes: reference encoding follows the select field
package adc_sel_pkg;
  typedef enum logic [1:0] {
    REF_EXTERNAL = 2'b00, // External reference pin
    REF_SUPPLY = 2'b01,   // Analog supply pin
    REF_RESERVED = 2'b10,
    REF_INTERNAL = 2'b11  // Internal 1.1V
  } reference_select_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
  typedef enum logic [2:0] {
    SLEEP_NONE = 3'b000,
    SLEEP_IDLE = 3'b001,
    SLEEP_NOISE = 3'b010,
    SLEEP_OTHER = 3'b011
  } sleep_mode_t;
endpackage

// ---- rtl/adc_clock_gen.sv ----
// Purpose: ADC clock enable generator (prescaled tick from pclk)
// Assumes: division ratio from a register, at least 1
// Notes: held in reset while converter is off or on clear request
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
module adc_clock_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear,
  input wire logic [7:0] divide,
  output logic tick
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic tick_next;

  // Tick on wrap; divide of 0 treated as 1
  assign tick_next = run && !clear && (count_reg + 8'h01 >= divide);
  assign count_next = (!run || clear || tick_next) ? 8'h00 : count_reg + 8'h01;

  // Counter and registered tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= tick_next;
    end
  end
endmodule // adc_clock_gen

// ---- rtl/adc_input_select_sync.sv ----
// Purpose: selection buffering, conversion sequencing and noise-canceler start
// Assumes: APB slave, pclk 10 MHz, sleep state from the core as plain inputs
// Notes: conversion datapath itself lives outside; this block times it
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
module adc_input_select_sync
  import adc_sel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_in,
  input wire logic cpu_halted,
  input wire adc_sel_pkg::sleep_mode_t sleep_mode,
  output logic [4:0] channel_select,
  output adc_sel_pkg::reference_select_t reference_select,
  output logic sample_hold,
  output logic conversion_done_pulse,
  output logic converter_powered,
  output logic irq_request
);
  import adc_sel_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  conv_state_t state_reg, state_next;
  logic [7:0] select_reg;
  logic [7:0] prescale_reg;
  logic converter_enable_reg;
  logic auto_trigger_enable_reg;
  logic conversion_done_flag_reg;
  logic irq_enable_reg;
  logic free_run_reg;
  logic start_req_reg;
  logic first_pending_reg;
  logic first_conv_reg;
  logic [4:0] cycle_reg;
  logic trig_meta_reg, trig_sync_reg, trig_prev_reg;
  logic halt_meta_reg, halt_sync_reg, halt_prev_reg;
  logic [2:0] sleep_meta_reg, sleep_sync_reg;
  logic adc_tick;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_select = (paddr == `ADDR_SELECT);
  wire hit_control = (paddr == `ADDR_CONTROL);
  wire hit_status = (paddr == `ADDR_STATUS);
  wire hit_prescale = (paddr == `ADDR_PRESCALE);
  wire mapped = hit_select || hit_control || hit_status || hit_prescale;
  wire wr_select = wr && hit_select;
  wire wr_control = wr && hit_control;
  wire wr_prescale = wr && hit_prescale;
  wire setup = psel && !penable;

  // ---------------------------------------------------------------
  // Input synchronisers (pins from other domains)
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      halt_meta_reg <= 1'b0;
      halt_sync_reg <= 1'b0;
      sleep_meta_reg <= 3'b000;
      sleep_sync_reg <= 3'b000;
    end else begin
      trig_meta_reg <= trigger_in;
      trig_sync_reg <= trig_meta_reg;
      halt_meta_reg <= cpu_halted;
      halt_sync_reg <= halt_meta_reg;
      sleep_meta_reg <= sleep_mode;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // Edge history, read only from the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
      halt_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sync_reg;
      halt_prev_reg <= halt_sync_reg;
    end
  end

  // ---------------------------------------------------------------
  // Start sources
  // ---------------------------------------------------------------
  wire busy = (state_reg != ST_IDLE);
  wire sleep_quiet = (sleep_sync_reg == SLEEP_IDLE) || (sleep_sync_reg == SLEEP_NOISE);
  // Halt edge in a quiet sleep mode starts a conversion
  wire canceler_start = halt_sync_reg && !halt_prev_reg && sleep_quiet;
  // Edge on trigger ignored while busy
  wire trig_edge = trig_sync_reg && !trig_prev_reg;
  wire auto_start = auto_trigger_enable_reg && trig_edge && !busy;
  wire sw_start = wr_control && pwdata[`CTL_START];
  // Free running: a completed conversion restarts at once
  wire last_cycle = (state_reg == ST_CONVERT) && adc_tick && (cycle_reg == 5'd1);
  wire free_restart = last_cycle && free_run_reg && auto_trigger_enable_reg;
  wire new_request = converter_enable_reg && (sw_start || auto_start || canceler_start);

  // Prescaler restarts on auto trigger so trigger-to-start delay is fixed
  adc_clock_gen u_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(converter_enable_reg),
    .clear(auto_start),
    .divide(prescale_reg),
    .tick(adc_tick)
  );

  // ---------------------------------------------------------------
  // Conversion state machine
  // ---------------------------------------------------------------
  wire [4:0] length = first_pending_reg ? `FIRST_CYCLES : `NORMAL_CYCLES;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (new_request) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // Start on the next ADC clock edge after the request
        if (adc_tick) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (adc_tick && cycle_reg == 5'd1) begin
          state_next = free_restart ? ST_CONVERT : ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!converter_enable_reg) begin
      state_next = ST_IDLE;
    end
  end

  // State, cycle counter and first-conversion bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 5'd0;
      first_pending_reg <= 1'b1;
      first_conv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (!converter_enable_reg) begin
        first_pending_reg <= 1'b1;
      end else if (state_reg == ST_ARMED && adc_tick) begin
        cycle_reg <= length;
        first_conv_reg <= first_pending_reg;
        first_pending_reg <= 1'b0;
      end else if (free_restart) begin
        cycle_reg <= `NORMAL_CYCLES;
        first_conv_reg <= 1'b0;
      end else if (state_reg == ST_CONVERT && adc_tick) begin
        cycle_reg <= cycle_reg - 5'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Selection lock
  // ---------------------------------------------------------------
  // Applied copy follows the buffer except during a conversion;
  // the final cycle reopens it so a pending write lands for the next one.
  // In free running the restart locks the value present now, so a write
  // made after the first completion only reaches the conversion after.
  wire in_last = (state_reg == ST_CONVERT) && (cycle_reg == 5'd1);
  wire track = (state_reg != ST_CONVERT) || in_last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= 5'd0;
      reference_select <= REF_EXTERNAL;
    end else if (track && !(state_reg == ST_ARMED && adc_tick)) begin
      channel_select <= select_reg[`SEL_CHAN_LSB +: `SEL_CHAN_W];
      reference_select <= reference_select_t'(select_reg[`SEL_REF_LSB +: 2]);
    end
    // Entering conversion holds the value latched while armed
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= `SELECT_RESET;
      prescale_reg <= `PRESCALE_RESET;
    end else begin
      if (wr_select) begin
        select_reg <= pwdata[7:0];
      end
      if (wr_prescale) begin
        prescale_reg <= pwdata[7:0];
      end
    end
  end

  // Control bits; done flag set wins over write-one clear
  wire done_set = last_cycle;
  wire done_clr = wr_control && pwdata[`CTL_DONE];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable_reg <= 1'b0;
      auto_trigger_enable_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
      free_run_reg <= 1'b0;
      conversion_done_flag_reg <= 1'b0;
    end else begin
      if (wr_control) begin
        converter_enable_reg <= pwdata[`CTL_ENABLE];
        auto_trigger_enable_reg <= pwdata[`CTL_AUTO];
        irq_enable_reg <= pwdata[`CTL_IRQ_EN];
        free_run_reg <= pwdata[`CTL_FREE];
      end
      if (done_set) begin
        conversion_done_flag_reg <= 1'b1;
      end else if (done_clr) begin
        conversion_done_flag_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Start bit reads busy; done pulse and request independent of wakeups
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_req_reg <= 1'b0;
      sample_hold <= 1'b0;
      conversion_done_pulse <= 1'b0;
      converter_powered <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      start_req_reg <= busy && state_next != ST_IDLE;
      sample_hold <= (state_next == ST_CONVERT);
      conversion_done_pulse <= done_set;
      // Power follows enable only; sleep never switches it off
      converter_powered <= converter_enable_reg;
      irq_request <= irq_enable_reg && (conversion_done_flag_reg || done_set);
    end
  end

  // ---------------------------------------------------------------
  // APB read data and response
  // ---------------------------------------------------------------
  wire [31:0] rd_select = {24'h000000, select_reg};
  wire [31:0] rd_control = {24'h000000, converter_enable_reg, start_req_reg || state_reg == ST_ARMED,
                            auto_trigger_enable_reg, conversion_done_flag_reg, irq_enable_reg,
                            free_run_reg, 2'b00};
  wire [31:0] rd_status = {22'h000000, irq_request, channel_select, reference_select,
                           first_conv_reg, busy};
  wire [31:0] rd_prescale = {24'h000000, prescale_reg};
  wire [31:0] rd_mux = hit_select ? rd_select :
                       hit_control ? rd_control :
                       hit_status ? rd_status :
                       hit_prescale ? rd_prescale : 32'h00000000;

  // Zero-wait-state slave: answer registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      // Captured at the setup edge so the word stands through the access cycle
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule // adc_input_select_sync

// ---- test/adc_sel_props.sv ----
// Purpose: port-level checks for the selection and sequencing block
// Assumes: the bench keeps the prescale divide at 1
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module adc_sel_props
  import adc_sel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] channel_select,
  input wire adc_sel_pkg::reference_select_t reference_select,
  input wire logic sample_hold,
  input wire logic conversion_done_pulse,
  input wire logic irq_request
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [4:0] wsel_reg;
  logic [5:0] hold_reg;
  wire any_wr = psel && penable && pwrite;
  wire sel_wr = any_wr && paddr == 12'h000;
  // Last written channel, and length of the current hold window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsel_reg <= 5'h00;
      hold_reg <= 6'h00;
    end else begin
      wsel_reg <= sel_wr ? pwdata[4:0] : wsel_reg;
      // Restart at each completion: free running keeps the hold high across restarts
      hold_reg <= !sample_hold ? 6'h00 : (conversion_done_pulse ? 6'h01 : hold_reg + 6'h01);
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_tracks_buffer: assert property (sel_wr && !sample_hold |-> ##[1:2] channel_select == wsel_reg)
    else $error("idle selection not copied");
  a_hold_frozen: assert property ($rose(sample_hold) |=> ($stable(channel_select) && $stable(reference_select))[*8])
    else $error("selection moved during conversion");
  a_conv_length: assert property (conversion_done_pulse |-> hold_reg >= 6'd12 && hold_reg <= 6'd26)
    else $error("conversion length wrong");
  a_done_after_hold: assert property ($fell(sample_hold) |-> ##[0:2] conversion_done_pulse)
    else $error("no completion after conversion");
  a_pulse_single: assert property (conversion_done_pulse |=> !conversion_done_pulse) else $error("done pulse too long");
  a_irq_has_cause: assert property ($rose(irq_request) |-> $past(any_wr) || $past(sample_hold) || $past(sample_hold, 2))
    else $error("request without cause");
  c_conv_end: cover property ($fell(sample_hold));
  c_irq_done: cover property (conversion_done_pulse && irq_request);
  c_refused: cover property (pslverr);
endmodule // adc_sel_props

bind adc_input_select_sync adc_sel_props props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .channel_select(channel_select), .reference_select(reference_select), .sample_hold(sample_hold),
  .conversion_done_pulse(conversion_done_pulse), .irq_request(irq_request));

// ---- test/core_sleep_model.sv ----
// Purpose: behavioural core and sleep controller facing the block
// Assumes: bench asks for sleep and triggers by plain requests
// Notes: mode settles one cycle before the halt is shown
`timescale 1ns/1ps
module core_sleep_model
  import adc_sel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_req,
  input wire adc_sel_pkg::sleep_mode_t req_mode,
  input wire logic trig_req,
  output logic cpu_halted,
  output adc_sel_pkg::sleep_mode_t sleep_mode,
  output logic trigger_in
);
  // Halt follows the mode so the block never sees a halt with no mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halted <= 1'b0;
      sleep_mode <= SLEEP_NONE;
      trigger_in <= 1'b0;
    end else begin
      sleep_mode <= sleep_req ? req_mode : SLEEP_NONE;
      cpu_halted <= sleep_req && sleep_mode != SLEEP_NONE;
      trigger_in <= trig_req;
    end
  end
endmodule // core_sleep_model

// ---- test/adc_input_select_sync_bench.sv ----
// Purpose: self-checking bench for the selection and sequencing block
// Assumes: prescale divide left at its reset value of 1
// Notes: tasks wait on the design; only the watchdog bounds a wait
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
`define CHECK(s, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", s, e, g); end end
module adc_input_select_sync_bench;
  import adc_sel_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0, trig_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cpu_halted, trigger_in, sample_hold, conversion_done_pulse;
  logic converter_powered, irq_request;
  logic [4:0] channel_select;
  reference_select_t reference_select;
  sleep_mode_t sleep_mode;
  sleep_mode_t req_mode = SLEEP_NONE;
  int fails = 0, compares = 0, n = 0, cyc = 0, t0 = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  adc_input_select_sync DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
    .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .channel_select(channel_select),
    .reference_select(reference_select), .sample_hold(sample_hold), .conversion_done_pulse(conversion_done_pulse),
    .converter_powered(converter_powered), .irq_request(irq_request));
  core_sleep_model core (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req), .req_mode(req_mode),
    .trig_req(trig_req), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode), .trigger_in(trigger_in));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for hold start or for the done pulse, counting cycles in n
  task automatic wait_for(input bit hold);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((hold ? sample_hold : conversion_done_pulse) !== 1'b1);
  endtask
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ADDR_SELECT, 0);
    `CHECK("select reset", 32'h0, rd)
    apb(0, `ADDR_PRESCALE, 0);
    `CHECK("prescale reset", 32'h1, rd)
    apb(1, 12'h010, 32'hff);
    `CHECK("unmapped write", 1'b1, err)
    apb(0, 12'h010, 0);
    `CHECK("unmapped read", 32'h0, rd)
    $display("test reset done");
    apb(1, `ADDR_CONTROL, 32'h88);
    apb(1, `ADDR_SELECT, 32'h45);
    apb(0, `ADDR_SELECT, 0);
    `CHECK("select readback", 32'h45, rd)
    `CHECK("idle channel", 5'h05, channel_select)
    `CHECK("idle reference", REF_SUPPLY, reference_select)
    $display("test idle done");
    apb(1, `ADDR_CONTROL, 32'hc8);
    t0 = cyc;
    wait_for(1);
    `CHECK("start delay", 1'b1, n <= 3)
    apb(1, `ADDR_SELECT, 32'hc3);
    apb(0, `ADDR_CONTROL, 0);
    `CHECK("start reads one", 1'b1, rd[6])
    apb(0, `ADDR_STATUS, 0);
    `CHECK("locked channel", 5'h05, rd[8:4])
    apb(0, `ADDR_SELECT, 0);
    `CHECK("buffer readback", 32'hc3, rd)
    wait_for(0);
    `CHECK("first length", 1'b1, cyc - t0 >= 25 && cyc - t0 <= 28)
    `CHECK("resumed channel", 5'h03, channel_select)
    `CHECK("internal reference", REF_INTERNAL, reference_select)
    apb(0, `ADDR_CONTROL, 0);
    `CHECK("start cleared", 8'h98, rd[7:0])
    apb(1, `ADDR_CONTROL, 32'hc8);
    t0 = cyc;
    wait_for(0);
    `CHECK("normal length", 1'b1, cyc - t0 >= 13 && cyc - t0 <= 16)
    $display("test single done");
    apb(1, `ADDR_CONTROL, 32'hec);
    wait_for(0);
    apb(1, `ADDR_SELECT, 32'hc7);
    `CHECK("free old channel", 5'h03, channel_select)
    wait_for(0);
    repeat (3) @(posedge pclk);
    `CHECK("free new channel", 5'h07, channel_select)
    apb(1, `ADDR_CONTROL, 32'h98);
    wait_for(0);
    apb(1, `ADDR_CONTROL, 32'h98);
    $display("test free run done");
    apb(1, `ADDR_SELECT, 32'h42);
    apb(1, `ADDR_CONTROL, 32'ha8);
    trig_req <= 1'b1;
    wait_for(1);
    trig_req <= 1'b0;
    `CHECK("trigger channel", 5'h02, channel_select)
    wait_for(0);
    apb(1, `ADDR_CONTROL, 32'h98);
    $display("test trigger done");
    for (int i = 1; i < 3; i++) begin
      apb(1, `ADDR_CONTROL, 32'h88);
      req_mode <= sleep_mode_t'(i);
      sleep_req <= 1'b1;
      wait_for(1);
      `CHECK("sleep start", 1'b1, n == 7)
      sleep_req <= 1'b0;
      wait_for(0);
      repeat (2) @(posedge pclk);
      `CHECK("early wake request", 1'b1, irq_request)
      apb(1, `ADDR_CONTROL, 32'h98);
    end
    req_mode <= SLEEP_OTHER;
    sleep_req <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHECK("other sleep power", 1'b1, converter_powered)
    `CHECK("other sleep idle", 1'b0, sample_hold)
    sleep_req <= 1'b0;
    apb(1, `ADDR_CONTROL, 32'h0);
    repeat (2) @(posedge pclk);
    `CHECK("power off", 1'b0, converter_powered)
    $display("test sleep done");
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(100 * 20000);
    fails++;
    end_of_test();
  end
endmodule // adc_input_select_sync_bench
